// ### rtl/crf_pkg.sv
// package: constants for the character recognition / flow control block
// assumes: one 125 MHz clock, synchronous active-high reset
package crf_pkg;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned FILL_W = 9;
  localparam logic [7:0] FLOW_ON_RST = 8'h11;
  localparam logic [7:0] FLOW_OFF_RST = 8'h13;
  localparam logic [7:0] BREAK_CHAR = 8'h00;
  localparam logic [8:0] RX_HIGH_LEVEL = 9'h0F0;
  localparam logic [8:0] RX_LOW_LEVEL = 9'h010;
  // flow mode field of mode_reg_three
  localparam logic [1:0] FLOW_HOST = 2'h0;
  localparam logic [1:0] FLOW_AUTO_TX = 2'h1;
  localparam logic [1:0] FLOW_AUTO_RX = 2'h2;
  localparam logic [1:0] FLOW_AUTO_BOTH = 2'h3;
  // field positions
  localparam int unsigned MR3_FLOW_LO = 2;
  localparam int unsigned MR3_DISCARD_BIT = 7;
  localparam int unsigned MR0_STRIP_LO = 6;
  localparam int unsigned CMD_CODE_LO = 3;
  // command codes in command bits 7:3
  localparam logic [4:0] CMD_FLOW_RESUME = 5'h16;
  localparam logic [4:0] CMD_SEND_ON = 5'h14;
  localparam logic [4:0] CMD_SEND_OFF = 5'h15;
  localparam logic [4:0] CMD_KILL_SEND = 5'h17;
  localparam logic [4:0] CMD_TX_DISABLE = 5'h09;
  localparam logic [4:0] CMD_TX_ENABLE = 5'h08;
  localparam logic [4:0] CMD_TX_RESET = 5'h03;
  // recognition status layout
  localparam int unsigned RS_MATCH0 = 0;
  localparam int unsigned RS_ON_SEEN = 1;
  localparam int unsigned RS_OFF_SEEN = 2;
  localparam int unsigned RS_TX_HELD = 3;
  localparam int unsigned RS_LAST_OFF = 4;
  localparam int unsigned ISR_RECOG_BIT = 4;
  typedef enum logic [1:0] {
    CRF_INS_NONE,
    CRF_INS_ON,
    CRF_INS_OFF
  } crf_ins_t;
endpackage

// ### rtl/crf_char_if.sv
// interface: one character with error flag between the block's modules
// assumes: same clock on both sides
interface crf_char_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic err;
  modport src (output valid, output data, output err, input ready);
  modport dst (input valid, input data, input err, output ready);
endinterface

// ### rtl/crf_skid_buf.sv
// two-entry buffer on the receive queue write path
// assumes: same clock on both sides, stall from queue full
module crf_skid_buf (
  // clock, reset
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // ports
  crf_char_if.dst up,
  crf_char_if.src dn
);
  logic [8:0] mem_r [2];
  logic [1:0] cnt_r;
  logic rd_r;
  logic wr_r;
  logic push;
  logic pop;

  assign up.ready = (cnt_r != 2'h2);
  assign dn.valid = (cnt_r != 2'h0);
  assign dn.data = mem_r[rd_r][7:0];
  assign dn.err = mem_r[rd_r][8];
  assign push = ce_in && up.valid && up.ready;
  assign pop = ce_in && dn.valid && dn.ready;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_r <= 2'h0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= ~wr_r;
      end
      if (pop) begin
        rd_r <= ~rd_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

  // data held in flops, not reset: valid count guards them
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wr_r] <= {up.err, up.data};
    end
  end
endmodule // crf_skid_buf

// ### rtl/crf_cmp3.sv
// three parallel character comparators
// assumes: all inputs from logic on the same clock
module crf_cmp3 (
  // character under test
  input wire logic [7:0] char_in,
  // compare values
  input wire logic [7:0] addr_char_in,
  input wire logic [7:0] on_char_in,
  input wire logic [7:0] off_char_in,
  // hits
  output logic [2:0] hit_out
);
  logic [7:0] ref_w [3];
  assign ref_w[0] = addr_char_in;
  assign ref_w[1] = on_char_in;
  assign ref_w[2] = off_char_in;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cmp
      // a break's 00 compares like any other data
      assign hit_out[g] = (char_in == ref_w[g]);
    end
  endgenerate
endmodule // crf_cmp3

// ### rtl/crf_flow_ctrl.sv
// character recognition and in-band flow control of one channel
// assumes: receiver hands over characters with error flag; queue fill
// levels and command writes come from same-clock logic.
// Function
// - three programmable recognition characters, for interrupt, wake or flow.
// - every received character not lost to overrun compared; match sets recognition and int status.
// - reading recognition status clears its recognition event bits.
// - reset loads flow-on and flow-off characters with standard values.
// - standard values are 11 and 13 hex; recognition uses the registers.
// - mode zero bits 7:6 pick stripping; actions happen either way.
// - recognized character with error is written to the queue anyway.
// - flow mode 00 host, 01 auto tx, 10 auto rx, 11 both.
// - mode three bit 7 discards flow characters, regardless of flow mode.
// - host mode uses commands; send-flow-off stops tx like received off.
// - host flow-off holds tx until reset or resume command 1 0110.
// - repeated send commands harmless; on and off may cancel each other.
// - auto tx: received off lets current character finish then stops.
// - auto tx stop ends by flow-on, reset or leaving auto tx mode; reset drops queue.
// - while awaiting flow-on in auto tx, transmitter commands are ignored.
// - while held, transmit queue writes, fill level and status stay live.
// - break's 00 character is compared like serial data.
// - flow character on full queue is overrun: ignored and not stored.
// - auto rx sends flow-off when receive fill reaches 240.
// - mode 11 sends off as queue fills and on when it drains.
// - auto rx sends flow-on when fill falls below 16.
// - current shift character finishes before inserted flow character.
module crf_flow_ctrl (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic soft_rst_in,
  // receiver side
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_char_in,
  input wire logic rx_err_in,
  output logic rx_ready_out,
  // receive queue write side
  output logic rq_valid_out,
  output logic [7:0] rq_data_out,
  output logic rq_err_out,
  input wire logic rq_ready_in,
  input wire logic [8:0] rq_fill_in,
  output logic rx_overrun_out,
  // configuration
  input wire logic [7:0] mode_reg_zero_in,
  input wire logic [7:0] mode_reg_three_in,
  input wire logic [7:0] addr_char_in,
  input wire logic on_char_we_in,
  input wire logic off_char_we_in,
  input wire logic [7:0] char_wdata_in,
  // command register write
  input wire logic command_register_we_in,
  input wire logic [7:0] command_register_in,
  // host status read
  input wire logic recog_status_rd_in,
  output logic [7:0] recognition_status_reg_out,
  output logic [7:0] interrupt_status_reg_out,
  output logic [7:0] on_char_out,
  output logic [7:0] off_char_out,
  // transmitter control
  input wire logic tx_shift_busy_in,
  output logic tx_enable_out,
  output logic tx_flush_out,
  output logic tx_cmd_ok_out,
  output logic ins_req_out,
  output logic [7:0] ins_char_out,
  input wire logic ins_take_in
);
  logic [7:0] on_char_r;
  logic [7:0] off_char_r;
  logic [2:0] rstat_r;
  logic isr_recog_r;
  logic host_hold_r;
  logic auto_hold_r;
  logic tx_en_r;
  logic last_off_r;
  crf_pkg::crf_ins_t pend_r;
  logic [1:0] mode_r;
  logic [2:0] hit;
  logic acc;
  logic ovr;
  logic on_hit;
  logic off_hit;
  logic any_hit;
  logic discard;
  logic cmd_v;
  logic [4:0] code;
  logic auto_tx;
  logic auto_rx;
  logic rst_all;
  logic clr_rd;

  crf_char_if rx_if ();
  crf_char_if rq_if ();

  assign rst_all = srst_in || soft_rst_in;
  assign mode_r = mode_reg_three_in[crf_pkg::MR3_FLOW_LO +: 2];
  // decode of the flow mode field
  function automatic logic mode_has(input logic [1:0] m, input logic [1:0] b);
    mode_has = (m == b) || (m == crf_pkg::FLOW_AUTO_BOTH);
  endfunction
  assign auto_tx = mode_has(mode_r, crf_pkg::FLOW_AUTO_TX);
  assign auto_rx = mode_has(mode_r, crf_pkg::FLOW_AUTO_RX);

  crf_cmp3 u_cmp (
    .char_in(rx_char_in),
    .addr_char_in(addr_char_in),
    .on_char_in(on_char_r),
    .off_char_in(off_char_r),
    .hit_out(hit)
  );

  // overrun: a full path means the character is lost unseen
  assign rx_ready_out = 1'b1;
  assign acc = ce_in && rx_valid_in && rx_if.ready;
  assign ovr = ce_in && rx_valid_in && !rx_if.ready;
  assign rx_overrun_out = ovr;
  assign any_hit = acc && (hit != 3'h0);
  assign on_hit = acc && hit[1];
  assign off_hit = acc && hit[2];
  // strip field nonzero strips the wake character; bit 7 strips flow chars
  assign discard = !rx_err_in &&
    ((hit[0] && (mode_reg_zero_in[crf_pkg::MR0_STRIP_LO +: 2] != 2'h0)) ||
     ((hit[1] || hit[2]) &&
      mode_reg_three_in[crf_pkg::MR3_DISCARD_BIT]));
  assign rx_if.valid = rx_valid_in && !discard;
  assign rx_if.data = rx_char_in;
  assign rx_if.err = rx_err_in;

  crf_skid_buf u_buf (
    .mclk_in(mclk_in),
    .srst_in(rst_all),
    .ce_in(ce_in),
    .up(rx_if),
    .dn(rq_if)
  );
  assign rq_if.ready = rq_ready_in;
  assign rq_valid_out = rq_if.valid;
  assign rq_data_out = rq_if.data;
  assign rq_err_out = rq_if.err;

  assign code = command_register_in[crf_pkg::CMD_CODE_LO +: 5];
  assign cmd_v = ce_in && command_register_we_in;
  assign clr_rd = ce_in && recog_status_rd_in;

  // flow character registers
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      on_char_r <= crf_pkg::FLOW_ON_RST;
      off_char_r <= crf_pkg::FLOW_OFF_RST;
    end else if (ce_in) begin
      if (on_char_we_in) begin
        on_char_r <= char_wdata_in;
      end
      if (off_char_we_in) begin
        off_char_r <= char_wdata_in;
      end
    end
  end

  // recognition status: set wins over read clear
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      rstat_r[2:0] <= 3'h0;
      isr_recog_r <= 1'b0;
    end else if (ce_in) begin
      if (any_hit) begin
        rstat_r[2:0] <= (clr_rd ? 3'h0 : rstat_r[2:0]) | hit;
        isr_recog_r <= 1'b1;
      end else if (clr_rd) begin
        rstat_r[2:0] <= 3'h0;
        isr_recog_r <= 1'b0;
      end
    end
  end

  // host command holds
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      host_hold_r <= 1'b0;
    end else if (ce_in && cmd_v && !auto_tx && !auto_rx) begin
      if (code == crf_pkg::CMD_SEND_OFF) begin
        host_hold_r <= 1'b1;
      end else if (code == crf_pkg::CMD_FLOW_RESUME) begin
        host_hold_r <= 1'b0;
      end
    end
  end

  // auto transmit gating; waits for shift register via tx_enable
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      auto_hold_r <= 1'b0;
    end else if (ce_in) begin
      if (!auto_tx) begin
        auto_hold_r <= 1'b0;
      end else if (off_hit) begin
        auto_hold_r <= 1'b1;
      end else if (on_hit) begin
        auto_hold_r <= 1'b0;
      end
    end
  end

  // host enable/disable commands, ignored while awaiting flow-on
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      tx_en_r <= 1'b0;
    end else if (cmd_v && !auto_hold_r) begin
      if (code == crf_pkg::CMD_TX_ENABLE) begin
        tx_en_r <= 1'b1;
      end else if (code == crf_pkg::CMD_TX_DISABLE ||
                   code == crf_pkg::CMD_TX_RESET) begin
        tx_en_r <= 1'b0;
      end
    end
  end
  // queue writes stay open; only the shifter is gated
  assign tx_enable_out = tx_en_r && !host_hold_r && !auto_hold_r;
  assign tx_cmd_ok_out = !auto_hold_r;
  assign tx_flush_out = rst_all;

  // pending flow character to insert
  always_ff @(posedge mclk_in) begin
    if (rst_all) begin
      pend_r <= crf_pkg::CRF_INS_NONE;
      last_off_r <= 1'b0;
    end else if (ce_in) begin
      if (mode_r == crf_pkg::FLOW_HOST && cmd_v) begin
        if (code == crf_pkg::CMD_SEND_ON) begin
          pend_r <= crf_pkg::CRF_INS_ON;
        end else if (code == crf_pkg::CMD_SEND_OFF) begin
          pend_r <= crf_pkg::CRF_INS_OFF;
        end else if (code == crf_pkg::CMD_KILL_SEND) begin
          pend_r <= crf_pkg::CRF_INS_NONE;
        end
      end else if (mode_r == crf_pkg::FLOW_HOST) begin
        last_off_r <= 1'b0;
      end
      if (auto_rx && !ins_take_in) begin
        if (!last_off_r && rq_fill_in >= crf_pkg::RX_HIGH_LEVEL) begin
          pend_r <= crf_pkg::CRF_INS_OFF;
        end else if (last_off_r && rq_fill_in < crf_pkg::RX_LOW_LEVEL) begin
          pend_r <= crf_pkg::CRF_INS_ON;
        end else if (pend_r != crf_pkg::CRF_INS_NONE && last_off_r ==
                     (pend_r == crf_pkg::CRF_INS_OFF)) begin
          pend_r <= crf_pkg::CRF_INS_NONE;
        end
      end
      if (ins_take_in && pend_r != crf_pkg::CRF_INS_NONE) begin
        pend_r <= crf_pkg::CRF_INS_NONE;
        last_off_r <= (pend_r == crf_pkg::CRF_INS_OFF);
      end
    end
  end
  // inserted only once the shifter is free
  assign ins_req_out = (pend_r != crf_pkg::CRF_INS_NONE) &&
    !tx_shift_busy_in;
  assign ins_char_out = (pend_r == crf_pkg::CRF_INS_OFF) ? off_char_r :
    on_char_r;

  // sticky event bits below, live hold and last-sent bits above them
  assign recognition_status_reg_out = {3'h0, last_off_r,
    host_hold_r || auto_hold_r, rstat_r};
  assign interrupt_status_reg_out = {3'h0, isr_recog_r, 4'h0};
  assign on_char_out = on_char_r;
  assign off_char_out = off_char_r;

  chk_reset_chars: assert property (@(posedge mclk_in)
    srst_in |=> on_char_r == crf_pkg::FLOW_ON_RST &&
    off_char_r == crf_pkg::FLOW_OFF_RST)
    else $error("flow chars not restored by reset");
  chk_hit_sets: assert property (@(posedge mclk_in) disable iff (rst_all)
    any_hit |=> isr_recog_r && (rstat_r[2:0] & $past(hit)) == $past(hit))
    else $error("match did not set status");
  chk_read_clear: assert property (@(posedge mclk_in) disable iff (rst_all)
    clr_rd && !any_hit |=> rstat_r[2:0] == 3'h0)
    else $error("read did not clear status");
  chk_ovr_ignored: assert property (@(posedge mclk_in) disable iff (rst_all)
    ovr |-> !any_hit)
    else $error("overrun char recognized");
  chk_auto_stop: assert property (@(posedge mclk_in) disable iff (rst_all)
    auto_tx && off_hit && ce_in |=> !tx_enable_out)
    else $error("tx not stopped on flow-off");
  chk_host_hold: assert property (@(posedge mclk_in) disable iff (rst_all)
    host_hold_r && !(cmd_v && code == crf_pkg::CMD_FLOW_RESUME) |=>
    host_hold_r)
    else $error("host hold released early");
  chk_err_stored: assert property (@(posedge mclk_in) disable iff (rst_all)
    rx_valid_in && rx_err_in |-> rx_if.valid)
    else $error("errored char stripped");
  chk_high_off: assert property (@(posedge mclk_in) disable iff (rst_all)
    ce_in && auto_rx && !last_off_r && !ins_take_in &&
    rq_fill_in >= crf_pkg::RX_HIGH_LEVEL |=> pend_r == crf_pkg::CRF_INS_OFF)
    else $error("flow-off not queued at high level");
  chk_ins_wait: assert property (@(posedge mclk_in) disable iff (rst_all)
    tx_shift_busy_in |-> !ins_req_out)
    else $error("insert while shifter busy");
endmodule // crf_flow_ctrl

// ### testbench/crf_remote_model.sv
// remote station plus local shifter, facing the flow control block
// assumes: same clock as the block; a character lasts CHAR_CYC cycles
module crf_remote_model #(
  parameter int CHAR_CYC = 10
) (
  // clock, reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // local shifter
  input wire logic shift_start_in,
  output logic tx_shift_busy_out,
  // flow character insertion
  input wire logic ins_req_in,
  input wire logic [7:0] ins_char_in,
  output logic ins_take_out,
  // remote sender state
  input wire logic [7:0] on_char_in,
  input wire logic [7:0] off_char_in,
  output logic remote_paused_out
);
  logic [7:0] cnt_r;
  logic take_nxt;

  assign tx_shift_busy_out = (cnt_r != 8'h00);
  // never takes mid-shift, so a late insert waits for the current character to end
  assign take_nxt = ins_req_in && !tx_shift_busy_out && !ins_take_out;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_r <= 8'h00;
      ins_take_out <= 1'b0;
    end else begin
      ins_take_out <= take_nxt;
      if (take_nxt || (shift_start_in && !tx_shift_busy_out)) begin
        cnt_r <= 8'(CHAR_CYC);
      end else if (tx_shift_busy_out) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // remote sender stops on flow-off and resumes on flow-on
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      remote_paused_out <= 1'b0;
    end else if (ins_take_out && ins_char_in === off_char_in) begin
      remote_paused_out <= 1'b1;
    end else if (ins_take_out && ins_char_in === on_char_in) begin
      remote_paused_out <= 1'b0;
    end
  end
endmodule // crf_remote_model

// ### testbench/tb.sv
// self-checking bench for the flow control block
// assumes: remote model on the insert side, bench plays receiver and host
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce_in = 1'b1;
  logic soft_rst_in = 1'b0;
  logic rx_valid_in = 1'b0;
  logic [7:0] rx_char_in = 8'h00;
  logic rx_err_in = 1'b0;
  logic rq_ready_in = 1'b1;
  logic [8:0] rq_fill_in = 9'h000;
  logic [7:0] mode_reg_zero_in = 8'h00;
  logic [7:0] mode_reg_three_in = 8'h00;
  logic [7:0] addr_char_in = 8'h55;
  logic on_char_we_in = 1'b0;
  logic off_char_we_in = 1'b0;
  logic [7:0] char_wdata_in = 8'h00;
  logic command_register_we_in = 1'b0;
  logic [7:0] command_register_in = 8'h00;
  logic recog_status_rd_in = 1'b0;
  logic shift_start = 1'b0;
  logic ovr_seen = 1'b0;
  logic rx_ready_out, rq_valid_out, rq_err_out, rx_overrun_out;
  logic [7:0] rq_data_out, recognition_status_reg_out, on_char_out;
  logic [7:0] interrupt_status_reg_out, off_char_out, ins_char_out;
  logic tx_shift_busy_in, tx_enable_out, tx_flush_out, tx_cmd_ok_out;
  logic ins_req_out, ins_take_in, paused;
  logic [8:0] got_q[$];
  int fails = 0;
  int comparisons = 0;
  int i;

  always #4 mclk_in = ~mclk_in;

  crf_flow_ctrl DUT (.mclk_in, .srst_in, .ce_in, .soft_rst_in, .rx_valid_in,
    .rx_char_in, .rx_err_in, .rx_ready_out, .rq_valid_out, .rq_data_out,
    .rq_err_out, .rq_ready_in, .rq_fill_in, .rx_overrun_out,
    .mode_reg_zero_in, .mode_reg_three_in, .addr_char_in, .on_char_we_in,
    .off_char_we_in, .char_wdata_in, .command_register_we_in,
    .command_register_in, .recog_status_rd_in, .recognition_status_reg_out,
    .interrupt_status_reg_out, .on_char_out, .off_char_out,
    .tx_shift_busy_in, .tx_enable_out, .tx_flush_out, .tx_cmd_ok_out,
    .ins_req_out, .ins_char_out, .ins_take_in);

  crf_remote_model #(.CHAR_CYC(10)) remote (.mclk_in, .srst_in,
    .shift_start_in(shift_start), .tx_shift_busy_out(tx_shift_busy_in),
    .ins_req_in(ins_req_out), .ins_char_in(ins_char_out),
    .ins_take_out(ins_take_in), .on_char_in(on_char_out),
    .off_char_in(off_char_out), .remote_paused_out(paused));

  // queue side: record every word the block hands over
  always @(posedge mclk_in) begin
    if (rq_valid_out === 1'b1 && rq_ready_in === 1'b1) begin
      got_q.push_back({rq_err_out, rq_data_out});
    end
    if (rx_overrun_out === 1'b1) begin
      ovr_seen = 1'b1;
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic ck(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rx(input logic [7:0] c, input logic e);
    @(posedge mclk_in);
    rx_valid_in <= 1'b1;
    rx_char_in <= c;
    rx_err_in <= e;
    @(posedge mclk_in);
    rx_valid_in <= 1'b0;
    wt(2);
  endtask

  task automatic cmd(input logic [4:0] code);
    @(posedge mclk_in);
    command_register_we_in <= 1'b1;
    command_register_in <= {code, 3'b000};
    @(posedge mclk_in);
    command_register_we_in <= 1'b0;
    wt(2);
  endtask

  // host status read, also forgets what the queue side saw
  task automatic clr;
    @(posedge mclk_in);
    recog_status_rd_in <= 1'b1;
    @(posedge mclk_in);
    recog_status_rd_in <= 1'b0;
    wt(2);
    got_q.delete();
    ovr_seen = 1'b0;
  endtask

  task automatic mode(input logic [1:0] f, input logic d);
    @(posedge mclk_in);
    mode_reg_three_in <= {d, 3'b000, f, 2'b00};
    wt(1);
  endtask

  task automatic results;
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    results();
  end

  initial begin
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    wt(1);
    ck(on_char_out, 9'h011);
    ck(off_char_out, 9'h013);
    ck(recognition_status_reg_out, 9'h000);
    cmd(crf_pkg::CMD_TX_ENABLE);
    ck(tx_enable_out, 9'h001);
    // host mode commands
    cmd(crf_pkg::CMD_SEND_ON);
    cmd(crf_pkg::CMD_SEND_ON);
    ck(tx_enable_out, 9'h001);
    cmd(crf_pkg::CMD_SEND_OFF);
    ck(tx_enable_out, 9'h000);
    rx(8'h11, 1'b0);
    ck(tx_enable_out, 9'h000);
    cmd(crf_pkg::CMD_TX_DISABLE);
    cmd(crf_pkg::CMD_TX_ENABLE);
    ck(tx_enable_out, 9'h000);
    cmd(crf_pkg::CMD_FLOW_RESUME);
    ck(tx_enable_out, 9'h001);
    clr();
    ck(recognition_status_reg_out[2:0], 9'h000);
    ck(interrupt_status_reg_out[4], 9'h000);
    // automatic transmit gating
    mode(crf_pkg::FLOW_AUTO_TX, 1'b0);
    rx(8'h13, 1'b0);
    ck(recognition_status_reg_out[2], 9'h001);
    ck(interrupt_status_reg_out[4], 9'h001);
    ck(tx_enable_out, 9'h000);
    ck(tx_cmd_ok_out, 9'h000);
    ck(tx_flush_out, 9'h000);
    cmd(crf_pkg::CMD_TX_DISABLE);
    rx(8'h11, 1'b0);
    ck(tx_enable_out, 9'h001);
    ck(got_q[0], 9'h013);
    ck(got_q[1], 9'h011);
    // stripping of flow and address characters, error kept
    clr();
    mode(crf_pkg::FLOW_HOST, 1'b1);
    mode_reg_zero_in <= 8'hC0;
    rx(8'h13, 1'b0);
    rx(8'h55, 1'b0);
    rx(8'h13, 1'b1);
    rx(8'h41, 1'b0);
    ck(recognition_status_reg_out[2:0], 9'h005);
    ck(9'(got_q.size()), 9'h002);
    ck(got_q[0], 9'h113);
    ck(got_q[1], 9'h041);
    // break character against a programmed 00
    clr();
    @(posedge mclk_in);
    on_char_we_in <= 1'b1;
    char_wdata_in <= 8'h00;
    @(posedge mclk_in);
    on_char_we_in <= 1'b0;
    wt(2);
    ck(on_char_out, 9'h000);
    rx(8'h00, 1'b0);
    ck(recognition_status_reg_out[1], 9'h001);
    // software reset
    @(posedge mclk_in);
    soft_rst_in <= 1'b1;
    wt(2);
    ck(tx_flush_out, 9'h001);
    @(posedge mclk_in);
    soft_rst_in <= 1'b0;
    wt(1);
    ck(on_char_out, 9'h011);
    ck(tx_enable_out, 9'h000);
    cmd(crf_pkg::CMD_TX_ENABLE);
    // overrun: flow-off lands on a full buffer
    mode(crf_pkg::FLOW_AUTO_TX, 1'b0);
    clr();
    rq_ready_in <= 1'b0;
    rx(8'h41, 1'b0);
    rx(8'h42, 1'b0);
    rx(8'h13, 1'b0);
    ck(ovr_seen, 9'h001);
    ck(recognition_status_reg_out[2], 9'h000);
    ck(tx_enable_out, 9'h001);
    rq_ready_in <= 1'b1;
    wt(6);
    ck(9'(got_q.size()), 9'h002);
    ck(got_q[0], 9'h041);
    ck(got_q[1], 9'h042);
    // fill-driven insertion, receive-only and combined
    for (int m = 2; m < 4; m++) begin
      mode(2'(m), 1'b0);
      rq_fill_in <= 9'h0EF;
      wt(20);
      ck(ins_req_out, 9'h000);
      rq_fill_in <= 9'h0F0;
      shift_start <= 1'b1;
      wt(1);
      shift_start <= 1'b0;
      for (i = 0; i < 60 && ins_req_out !== 1'b1; i++) wt(1);
      ck(ins_char_out, 9'h013);
      for (i = 0; i < 60 && paused !== 1'b1; i++) wt(1);
      ck(paused, 9'h001);
      rq_fill_in <= 9'h010;
      wt(20);
      ck(ins_req_out, 9'h000);
      rq_fill_in <= 9'h00F;
      for (i = 0; i < 60 && ins_req_out !== 1'b1; i++) wt(1);
      ck(ins_char_out, 9'h011);
      for (i = 0; i < 60 && paused !== 1'b0; i++) wt(1);
      ck(paused, 9'h000);
      rq_fill_in <= 9'h000;
    end
    results();
  end
endmodule // tb
